// File: logic/clock_routing_pkg.sv
package clock_routing_pkg;

  // ----------------------------------------------------------------
  // widths and counts
  // ----------------------------------------------------------------
  localparam int NUM_OUT = 6;
  localparam int DIV_W   = 11;
  localparam int DLY_W   = 4;
  localparam int ADLY_W  = 5;
  localparam int DLY_DEPTH = 16;

  // ----------------------------------------------------------------
  // device mode codes and feedback choices
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_DUAL       = 3'h0;
  localparam logic [2:0] MODE_SINGLE     = 3'h1;
  localparam logic [2:0] MODE_DIST       = 3'h2;
  localparam logic [2:0] MODE_EXT_OSC    = 3'h3;
  localparam logic [2:0] MODE_ZERO_DELAY = 3'h4;
  localparam logic [2:0] FB_EXTERNAL     = 3'h6;
  // distribution outputs that may take the oscillator input directly
  localparam int OSC_CHAN_A = 3;
  localparam int OSC_CHAN_B = 4;

  // ----------------------------------------------------------------
  // register byte offsets, masks and reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] OFF_MODE   = 6'h00;
  localparam logic [5:0] OFF_PREDIV = 6'h04;
  localparam logic [5:0] OFF_LOOP1  = 6'h08;
  localparam logic [5:0] OFF_LOOP2  = 6'h0c;
  localparam logic [5:0] OFF_CHAN0  = 6'h10;
  localparam logic [5:0] OFF_STATUS = 6'h28;
  localparam logic [31:0] MASK_MODE   = 32'h00001fff;
  localparam logic [31:0] MASK_PREDIV = 32'h0000077f;
  localparam logic [31:0] MASK_LOOP1  = 32'h07ff07ff;
  localparam logic [31:0] MASK_LOOP2  = 32'h77ff07ff;
  localparam logic [31:0] MASK_CHAN   = 32'h031ff7ff;
  localparam logic [31:0] RST_MODE    = 32'h00000008;
  localparam logic [31:0] RST_PREDIV  = 32'h00000220;
  localparam logic [31:0] RST_LOOP1   = 32'h00010001;
  localparam logic [31:0] RST_LOOP2   = 32'h20010001;
  localparam logic [31:0] RST_CHAN    = 32'h00000001;

  // field positions
  localparam int F_MODE = 0;  // [2:0]
  localparam int F_AUTO = 3;
  localparam int F_MANUAL_B = 4;
  localparam int F_PIN_SEL = 5;
  localparam int F_XTAL = 6;
  localparam int F_OSCDIV_EN = 7;
  localparam int F_VCODIV_EN = 8;
  localparam int F_OSCBUF_EXEMPT = 9;
  localparam int F_FB_SRC = 10;  // [12:10]
  localparam int F_PRE_A = 0;    // [1:0]
  localparam int F_PRE_B = 2;    // [3:2]
  localparam int F_OSCDIV = 4;   // [6:4]
  localparam int F_VCODIV = 8;   // [10:8]
  localparam int F_R = 0;        // [10:0]
  localparam int F_N = 16;       // [26:16]
  localparam int F_PRESC = 28;   // [30:28]
  localparam int F_DIV = 0;      // [10:0]
  localparam int F_DLY = 12;     // [15:12]
  localparam int F_ADLY = 16;    // [20:16]
  localparam int F_OSC_SRC = 24;
  localparam int F_EXEMPT = 25;
  localparam logic [2:0] OSC_DIV_MIN = 3'h2;

  // ----------------------------------------------------------------
  // reference loss timing
  // ----------------------------------------------------------------
  localparam int LOSS_TIME_NS = 1000;
  localparam int CLK_MHZ = 200;
  localparam int LOSS_CYCLES = LOSS_TIME_NS * CLK_MHZ / 1000;
  localparam logic [7:0] LOSS_LIMIT = 8'(LOSS_CYCLES);

endpackage

// File: logic/edge_divider.sv
`timescale 1ns/100ps
module edge_divider
  import clock_routing_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             clear,
  input  wire logic [DIV_W-1:0] divide,
  input  wire logic             clkIn,
  output logic                  clkOut
);

  // ----------------------------------------------------------------
  // divider on both input edges
  // ----------------------------------------------------------------
  logic             prevIn;
  logic [DIV_W-1:0] edgeCount;
  logic [DIV_W-1:0] next_edgeCount;
  logic             next_clkOut;
  logic             inEdge;

  assign inEdge = clkIn ^ prevIn;

  // toggling every N edges keeps 50% duty for odd N too
  always_comb begin
    next_edgeCount = edgeCount;
    next_clkOut    = clkOut;
    if (clear) begin
      next_edgeCount = '0;
      next_clkOut    = 1'b0;
    end else if (divide <= DIV_W'(1)) begin
      next_edgeCount = '0;
      next_clkOut    = clkIn;  // bypass, still registered
    end else if (inEdge) begin
      if (edgeCount >= divide - DIV_W'(1)) begin  // R20
        next_edgeCount = '0;
        next_clkOut    = ~clkOut;
      end else begin
        next_edgeCount = edgeCount + DIV_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prevIn    <= 1'b0;
      edgeCount <= '0;
      clkOut    <= 1'b0;
    end else begin
      prevIn    <= clkIn;
      edgeCount <= next_edgeCount;
      clkOut    <= next_clkOut;
    end
  end

endmodule // edge_divider

// File: logic/delay_stage.sv
`timescale 1ns/100ps
module delay_stage
  import clock_routing_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [DLY_W-1:0] tap,
  input  wire logic             dataIn,
  output logic                  dataOut
);

  // ----------------------------------------------------------------
  // coarse delay line, tap picked per output
  // ----------------------------------------------------------------
  logic [DLY_DEPTH-1:0] line;
  logic [DLY_DEPTH-1:0] next_line;
  logic                 next_dataOut;

  // tap 0 still costs the output register, so delay is tap plus one
  always_comb begin
    next_line    = {line[DLY_DEPTH-2:0], dataIn};
    next_dataOut = (tap == '0) ? dataIn : line[tap - DLY_W'(1)];
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      line    <= '0;
      dataOut <= 1'b0;
    end else begin
      line    <= next_line;
      dataOut <= next_dataOut;
    end
  end

endmodule // delay_stage

// File: logic/dual_loop_clock_routing.sv
// Contract
// R1: dual loop compares prediv+R divided active ref against N divided osc
// R2: second loop ref is osc through R; feedback via prescaler, N, opt div
// R3: six outputs each with divide, digital delay and analog delay
// R4: zero-delay routes a chosen output through feedback mux to first N
// R5: external osc mode feeds ref B pin to second loop; osc divider off
// R6: single loop powers down first loop; osc input drives second loop
// R7: distribution mode sends ref B through per-output divide and delays
// R8: reference mux picks A or B, automatic or manual
// R9: each reference has its own pre-divider ahead of first R divider
// R10: ref B pin reused for feedback or external osc leaves selection
// R11: select pins give fast manual reference choice
// R12: software must set crystal enable before crystal use
// R13: osc buffer output copies osc input, optionally divided by 2 to 8; the 3-bit field here divides by 7 at most
// R14: two outputs may take osc input directly
// R15: sync forces osc-sourced outputs low, asynchronously, unaligned
// R16: sync exempt bit keeps that buffered output running through sync
// R17: loss of reference enters holdover until reference returns
// R18: mode field decodes loop enable, feedback source, external osc path
// R19: pre-dividers divide by 1, 2, 4 or 8 only
// R20: oscillator divider divides 2 to 8 with 50 percent duty; the 3-bit field here divides by 7 at most
//
// Design decisions made here: the address map and the Avalon-MM register port.
`timescale 1ns/100ps
module dual_loop_clock_routing
  import clock_routing_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  input  wire logic [5:0]                address,
  input  wire logic                      read,
  input  wire logic                      write,
  input  wire logic [31:0]               writedata,
  input  wire logic [3:0]                byteenable,
  output logic      [31:0]               readdata,
  output logic                           waitrequest,
  input  wire logic                      refInputA,
  input  wire logic                      refInputB,
  input  wire logic                      oscReferenceInput,
  input  wire logic                      vcoClockInput,
  input  wire logic                      selectPinA,
  input  wire logic                      selectPinB,
  input  wire logic                      syncIn,
  output logic      [NUM_OUT-1:0]        clkOut,
  output logic      [NUM_OUT*ADLY_W-1:0] analogDelayCode,
  output logic                           oscBufferOutput,
  output logic                           firstLoopRefClk,
  output logic                           firstLoopFbClk,
  output logic                           secondLoopRefClk,
  output logic                           secondLoopFbClk,
  output logic                           firstLoopPowerDown,
  output logic                           holdover,
  output logic                           activeRef,
  output logic                           crystalEnable
);

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  logic [31:0] modeReg, prediv, loop1, loop2;
  logic [31:0] next_modeReg, next_prediv, next_loop1, next_loop2;
  logic [31:0] chanReg [NUM_OUT];
  logic [31:0] next_chanReg [NUM_OUT];
  logic [31:0] next_readdata;
  logic        ack, next_ack;
  logic [31:0] statusWord;
  logic [1:0]  lost;
  logic        refBUsable;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [31:0] mask,
                                        input logic [3:0]  be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
    return (old & ~m) | (wd & m);
  endfunction

  // one wait cycle: read data caught early, write lands on release
  assign waitrequest = (read | write) & ~ack;

  always_comb begin
    next_ack      = (read | write) & ~ack;
    next_readdata = readdata;
    next_modeReg  = modeReg;
    next_prediv   = prediv;
    next_loop1    = loop1;
    next_loop2    = loop2;
    for (int i = 0; i < NUM_OUT; i++) begin
      next_chanReg[i] = chanReg[i];
    end
    if (read & ~ack) begin
      next_readdata = '0;  // unmapped reads give zero
      unique case (address)
        OFF_MODE:   next_readdata = modeReg;
        OFF_PREDIV: next_readdata = prediv;
        OFF_LOOP1:  next_readdata = loop1;
        OFF_LOOP2:  next_readdata = loop2;
        OFF_STATUS: next_readdata = statusWord;
        default: begin
          for (int i = 0; i < NUM_OUT; i++) begin
            if (address == OFF_CHAN0 + 6'(4 * i)) begin
              next_readdata = chanReg[i];
            end
          end
        end
      endcase
    end
    if (write & ack) begin
      unique case (address)
        OFF_MODE:
          next_modeReg = merge(modeReg, writedata, MASK_MODE, byteenable);
        OFF_PREDIV:
          next_prediv = merge(prediv, writedata, MASK_PREDIV, byteenable);
        OFF_LOOP1:
          next_loop1 = merge(loop1, writedata, MASK_LOOP1, byteenable);
        OFF_LOOP2:
          next_loop2 = merge(loop2, writedata, MASK_LOOP2, byteenable);
        default: begin
          for (int i = 0; i < NUM_OUT; i++) begin
            if (address == OFF_CHAN0 + 6'(4 * i)) begin
              next_chanReg[i] = merge(chanReg[i], writedata, MASK_CHAN,
                                      byteenable);
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack      <= 1'b0;
      readdata <= '0;
      modeReg  <= RST_MODE;
      prediv   <= RST_PREDIV;
      loop1    <= RST_LOOP1;
      loop2    <= RST_LOOP2;
      for (int i = 0; i < NUM_OUT; i++) begin
        chanReg[i] <= RST_CHAN;
      end
    end else begin
      ack      <= next_ack;
      readdata <= next_readdata;
      modeReg  <= next_modeReg;
      prediv   <= next_prediv;
      loop1    <= next_loop1;
      loop2    <= next_loop2;
      for (int i = 0; i < NUM_OUT; i++) begin
        chanReg[i] <= next_chanReg[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  logic [2:0] mode, fbSource, oscDivVal, vcoDivVal;
  logic       extOsc, zeroDelay, distMode, firstLoopEnable;

  assign mode            = modeReg[F_MODE +: 3];
  assign fbSource        = modeReg[F_FB_SRC +: 3];
  assign extOsc          = (mode == MODE_EXT_OSC);  // R18
  assign zeroDelay       = (mode == MODE_ZERO_DELAY);  // R18
  assign distMode        = (mode == MODE_DIST);
  assign firstLoopEnable = ~(mode == MODE_SINGLE) & ~distMode;  // R18
  assign firstLoopPowerDown = ~firstLoopEnable;  // R6
  assign crystalEnable   = modeReg[F_XTAL];  // R12
  // ref B pin taken by external osc, distribution mode or external feedback
  assign refBUsable = ~extOsc & ~distMode
                      & ~(zeroDelay & (fbSource == FB_EXTERNAL));  // R10
  assign statusWord = {26'h0, refBUsable, firstLoopPowerDown, lost,
                       holdover, activeRef};

  // ----------------------------------------------------------------
  // reference loss watch and selection
  // ----------------------------------------------------------------
  logic [1:0] refIn, refPrev;
  logic       next_activeRef, next_holdover, wantRef;

  assign refIn = {refInputB, refInputA};

  for (genvar g = 0; g < 2; g++) begin : g_loss
    logic [7:0] idleCount, next_idleCount;
    always_comb begin
      if (refIn[g] ^ refPrev[g]) begin
        next_idleCount = '0;
      end else if (idleCount == LOSS_LIMIT) begin
        next_idleCount = idleCount;
      end else begin
        next_idleCount = idleCount + 8'h01;
      end
    end
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        idleCount <= '0;
        refPrev[g] <= 1'b0;
      end else begin
        idleCount <= next_idleCount;
        refPrev[g] <= refIn[g];
      end
    end
    assign lost[g] = (idleCount == LOSS_LIMIT);
  end

  // pins outrank the register; neither or both pins keeps the choice
  always_comb begin
    wantRef = activeRef;
    if (~refBUsable) begin
      wantRef = 1'b0;  // R10
    end else if (modeReg[F_PIN_SEL]) begin
      if (selectPinA & ~selectPinB) begin
        wantRef = 1'b0;  // R11
      end else if (selectPinB & ~selectPinA) begin
        wantRef = 1'b1;  // R11
      end
    end else if (~modeReg[F_AUTO]) begin
      wantRef = modeReg[F_MANUAL_B];  // R8
    end else if (lost[activeRef] & ~lost[~activeRef]) begin
      wantRef = ~activeRef;  // R8
    end
    next_activeRef = wantRef;
    next_holdover  = firstLoopEnable & lost[wantRef];  // R17
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      activeRef <= 1'b0;
      holdover  <= 1'b0;
    end else begin
      activeRef <= next_activeRef;
      holdover  <= next_holdover;
    end
  end

  // ----------------------------------------------------------------
  // first loop dividers
  // ----------------------------------------------------------------
  logic [1:0]       preOut;
  logic [DIV_W-1:0] preDivide [2];
  logic             fbMuxClk;

  for (genvar g = 0; g < 2; g++) begin : g_pre
    // code 0..3 gives 1, 2, 4, 8
    assign preDivide[g] = DIV_W'(1) << prediv[2*g +: 2];  // R19
    edge_divider u_pre (  // R9
      .clk(clk), .reset_n(reset_n), .clear(firstLoopPowerDown),
      .divide(preDivide[g]), .clkIn(refIn[g]), .clkOut(preOut[g]));
  end

  // holdover freezes the comparison so the loop keeps its frequency
  edge_divider u_r1 (  // R1
    .clk(clk), .reset_n(reset_n), .clear(firstLoopPowerDown | holdover),
    .divide(loop1[F_R +: DIV_W]), .clkIn(preOut[activeRef]),
    .clkOut(firstLoopRefClk));

  always_comb begin
    fbMuxClk = oscReferenceInput;  // R1
    if (zeroDelay) begin
      if (fbSource == FB_EXTERNAL) begin
        fbMuxClk = refInputB;  // R4
      end else if (fbSource < 3'(NUM_OUT)) begin
        fbMuxClk = clkOut[fbSource];  // R4
      end
    end
  end

  edge_divider u_n1 (  // R1
    .clk(clk), .reset_n(reset_n), .clear(firstLoopPowerDown | holdover),
    .divide(loop1[F_N +: DIV_W]), .clkIn(fbMuxClk),
    .clkOut(firstLoopFbClk));

  // ----------------------------------------------------------------
  // second loop and distribution source
  // ----------------------------------------------------------------
  logic vcoSource, vcoDivOut, prescOut, distClock;
  logic vcoDivOn, oscBufRaw;

  assign oscDivVal = (prediv[F_OSCDIV +: 3] < OSC_DIV_MIN) ? OSC_DIV_MIN
                     : prediv[F_OSCDIV +: 3];
  assign vcoDivVal = (prediv[F_VCODIV +: 3] < OSC_DIV_MIN) ? OSC_DIV_MIN
                     : prediv[F_VCODIV +: 3];
  assign vcoSource = extOsc ? refInputB : vcoClockInput;  // R5
  assign vcoDivOn  = modeReg[F_VCODIV_EN] & ~extOsc;  // R5

  // osc input straight in whatever the first loop does; held clear in distribution mode
  edge_divider u_r2 (  // R2 R6
    .clk(clk), .reset_n(reset_n), .clear(distMode),
    .divide(loop2[F_R +: DIV_W]), .clkIn(oscReferenceInput),
    .clkOut(secondLoopRefClk));

  edge_divider u_vcodiv (  // R20
    .clk(clk), .reset_n(reset_n), .clear(1'b0),
    .divide(vcoDivOn ? DIV_W'(vcoDivVal) : DIV_W'(1)),
    .clkIn(vcoSource), .clkOut(vcoDivOut));

  assign distClock = distMode ? refInputB : vcoDivOut;  // R7

  edge_divider u_presc (  // R2
    .clk(clk), .reset_n(reset_n), .clear(distMode),
    .divide(DIV_W'(loop2[F_PRESC +: 3])), .clkIn(vcoDivOut),
    .clkOut(prescOut));

  edge_divider u_n2 (  // R2
    .clk(clk), .reset_n(reset_n), .clear(distMode),
    .divide(loop2[F_N +: DIV_W]), .clkIn(prescOut),
    .clkOut(secondLoopFbClk));

  // ----------------------------------------------------------------
  // buffered oscillator output
  // ----------------------------------------------------------------
  edge_divider u_oscdiv (  // R13
    .clk(clk), .reset_n(reset_n), .clear(1'b0),
    .divide(modeReg[F_OSCDIV_EN] ? DIV_W'(oscDivVal) : DIV_W'(1)),
    .clkIn(oscReferenceInput), .clkOut(oscBufRaw));

  // gate straight from the pin: asynchronous, may glitch on sync edges
  assign oscBufferOutput = oscBufRaw
                           & ~(syncIn & ~modeReg[F_OSCBUF_EXEMPT]);  // R15

  // ----------------------------------------------------------------
  // six distribution outputs
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_OUT; g++) begin : g_chan  // R3
    logic             oscSourced, chanDiv, chanDly;
    logic [DLY_W-1:0] dlyActive, next_dlyActive;
    assign oscSourced = chanReg[g][F_OSC_SRC]
                        & ((g == OSC_CHAN_A) | (g == OSC_CHAN_B));  // R14
    // new digital delay only takes effect on a sync event
    always_comb begin
      next_dlyActive = syncIn ? chanReg[g][F_DLY +: DLY_W] : dlyActive;
    end
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        dlyActive <= '0;
      end else begin
        dlyActive <= next_dlyActive;
      end
    end
    edge_divider u_div (  // R3 R7
      .clk(clk), .reset_n(reset_n), .clear(syncIn & ~oscSourced),
      .divide(chanReg[g][F_DIV +: DIV_W]),
      .clkIn(oscSourced ? oscReferenceInput : distClock),
      .clkOut(chanDiv));
    delay_stage u_dly (  // R3
      .clk(clk), .reset_n(reset_n), .tap(dlyActive),
      .dataIn(chanDiv), .dataOut(chanDly));
    assign clkOut[g] = chanDly & ~(oscSourced & syncIn
                                   & ~chanReg[g][F_EXEMPT]);  // R15 R16
    assign analogDelayCode[g*ADLY_W +: ADLY_W] =
      chanReg[g][F_ADLY +: ADLY_W];  // R3
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_bus_answer: assert property (
    (read | write) & waitrequest |=> ~waitrequest)
    else $error("bus request not answered in one wait cycle");
  a_single_quiet: assert property (  // R6
    firstLoopPowerDown [*2] |-> ~firstLoopRefClk & ~firstLoopFbClk)
    else $error("first loop still toggling while powered down");
  a_refb_excluded: assert property (  // R10
    ~refBUsable [*2] |-> ~activeRef)
    else $error("reused ref B pin still selected");
  a_pin_select: assert property (  // R11
    modeReg[F_PIN_SEL] & refBUsable & selectPinB & ~selectPinA
    |=> activeRef)
    else $error("select pin B did not pick reference B");
  a_manual_select: assert property (  // R8
    ~modeReg[F_PIN_SEL] & ~modeReg[F_AUTO] & refBUsable
    |=> activeRef == $past(modeReg[F_MANUAL_B]))
    else $error("manual reference choice not followed");
  a_holdover_entry: assert property (  // R17
    firstLoopEnable & lost[0] & lost[1] & $stable(modeReg)
    |=> holdover)
    else $error("holdover not entered on reference loss");
  a_holdover_exit: assert property (  // R17
    holdover & ~lost[activeRef] & $stable(modeReg) |=> ~holdover)
    else $error("holdover kept after reference returned");
  a_osc_forced_low: assert property (  // R15
    syncIn & ~modeReg[F_OSCBUF_EXEMPT] |-> ~oscBufferOutput)
    else $error("osc buffer output not low during sync");
  a_exempt_runs: assert property (  // R16
    syncIn & modeReg[F_OSCBUF_EXEMPT] |-> oscBufferOutput == oscBufRaw)
    else $error("exempt osc buffer output stopped by sync");

  c_switch_ref: cover property (activeRef ##1 ~activeRef);
  c_holdover: cover property ($rose(holdover) ##[1:400] $fell(holdover));
  c_sync_event: cover property ($rose(syncIn) ##[1:20] $fell(syncIn));

endmodule // dual_loop_clock_routing

// File: verif/ref_source_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// reference sources and tunable oscillator on the far side
// ----------------------------------------------------------------
module ref_source_model (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic enableA,
  input  wire logic enableB,
  output logic      refA,
  output logic      refB,
  output logic      osc,
  output logic      vco
);
  logic [3:0] count;
  // a stopped reference parks low, as a lost input would
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= 4'h0;
    end else begin
      count <= count + 4'h1;
    end
  end
  assign refA = enableA & count[2];
  assign refB = enableB & count[3];
  assign osc  = count[0];
  assign vco  = ~count[0];
endmodule // ref_source_model

// File: verif/test_dual_loop_clock_routing.sv
`timescale 1ns/100ps
module test_dual_loop_clock_routing
  import clock_routing_pkg::*;
;
  typedef struct {logic [5:0] a; logic [31:0] e;} row_s;
  logic clk, reset_n, read, write, selA, selB, syncIn, enA, enB;
  logic [5:0] address;
  logic [31:0] writedata, q;
  logic [3:0] byteenable;
  logic [31:0] readdata;
  logic waitrequest, refA, refB, osc, vco, oscBuf, pd, hold, act, xtal;
  logic [NUM_OUT-1:0] clkOut;
  logic [NUM_OUT*ADLY_W-1:0] adly;
  logic [3:0] lc;
  logic [6:0] mon;
  // outputs watched for toggling, one bit each
  assign mon = {clkOut[3], oscBuf, clkOut[0], lc};
  int n_errors, tests_run, k;
  row_s rows[6] = '{'{OFF_MODE, RST_MODE}, '{OFF_PREDIV, RST_PREDIV},
    '{OFF_LOOP1, RST_LOOP1}, '{OFF_LOOP2, RST_LOOP2},
    '{OFF_CHAN0, RST_CHAN}, '{6'h3c, 32'h0}};
  ref_source_model ref_source_model_inst (.clk(clk), .reset_n(reset_n),
    .enableA(enA), .enableB(enB), .refA(refA), .refB(refB), .osc(osc),
    .vco(vco));
  dual_loop_clock_routing dual_loop_clock_routing_inst (.clk(clk),
    .reset_n(reset_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .refInputA(refA), .refInputB(refB),
    .oscReferenceInput(osc), .vcoClockInput(vco), .selectPinA(selA),
    .selectPinB(selB), .syncIn(syncIn), .clkOut(clkOut),
    .analogDelayCode(adly), .oscBufferOutput(oscBuf),
    .firstLoopRefClk(lc[0]), .firstLoopFbClk(lc[1]),
    .secondLoopRefClk(lc[2]), .secondLoopFbClk(lc[3]),
    .firstLoopPowerDown(pd), .holdover(hold),
    .activeRef(act), .crystalEnable(xtal));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string n, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    k = 0;
    @(posedge clk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    do begin
      @(posedge clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 50);
    check("waitrequest", {31'h0, waitrequest}, 32'h0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    // one more edge so outputs fed by the new value have settled
    @(posedge clk);
  endtask
  // toggles of one watched output across n cycles
  task automatic toggles(input int b, input int n, output int t);
    logic p;
    t = 0;
    p = mon[b];
    repeat (n) begin
      @(posedge clk);
      t += p ^ mon[b];
      p = mon[b];
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // watchdog sized well above the whole sequence
  initial begin
    #100000;
    n_errors++;
    complete_run();
  end
  initial begin
    {reset_n, read, write, selA, selB, syncIn} = 6'h0;
    {enA, enB, address, writedata, byteenable} = {2'h3, 6'h0, 32'h0, 4'hf};
    n_errors = 0;
    tests_run = 0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    check("powerdown", {31'h0, pd}, 32'h0);
    foreach (rows[i]) begin
      bus(1'b0, rows[i].a, 32'h0);
      check("reset value", q, rows[i].e);
    end
    $display("register reset test done");
    for (int m = 0; m < 5; m++) begin
      bus(1'b1, OFF_MODE, 32'h8 | m);
      check("powerdown", {31'h0, pd}, {31'h0, m == 1 || m == 2});
    end
    bus(1'b1, OFF_MODE, 32'h28);
    for (int p = 0; p < 2; p++) begin
      selA <= p == 0;
      selB <= p == 1;
      repeat (4) @(posedge clk);
      check("activeRef pins", {31'h0, act}, p);
    end
    bus(1'b1, OFF_MODE, 32'h1a);
    repeat (2) @(posedge clk);
    check("activeRef dist", {31'h0, act}, 32'h0);
    toggles(4, 16, k);
    check("dist clock", k, 32'h2);
    $display("mode test done");
    bus(1'b1, OFF_PREDIV, 32'h231);
    bus(1'b1, OFF_MODE, 32'h48);
    check("crystal", {31'h0, xtal}, 32'h1);
    bus(1'b1, OFF_CHAN0, 32'h00050001);
    check("analog", {27'h0, adly[4:0]}, 32'h5);
    for (int b = 0; b < 4; b++) begin
      toggles(b, 16, k);
      check("loop clock", k, b == 0 ? 2 : b == 3 ? 8 : 16);
    end
    bus(1'b1, OFF_MODE, 32'h90);
    repeat (2) @(posedge clk);
    check("activeRef manual", {31'h0, act}, 32'h1);
    toggles(0, 16, k);
    check("ref B rate", k, 32'h2);
    toggles(5, 12, k);
    check("osc divide", k, 32'h4);
    {enA, enB} <= 2'h0;
    repeat (300) @(posedge clk);
    check("holdover", {31'h0, hold}, 32'h1);
    {enA, enB} <= 2'h3;
    repeat (60) @(posedge clk);
    check("holdover", {31'h0, hold}, 32'h0);
    bus(1'b1, OFF_CHAN0 + 6'hc, 32'h01000001);
    syncIn <= 1'b1;
    repeat (3) @(posedge clk);
    check("osc chan sync", {31'h0, clkOut[3]}, 32'h0);
    check("osc buffer sync", {31'h0, oscBuf}, 32'h0);
    bus(1'b1, OFF_CHAN0 + 6'hc, 32'h03000001);
    bus(1'b1, OFF_MODE, 32'h208);
    toggles(5, 4, k);
    check("exempt runs", 32'(k > 0), 32'h1);
    toggles(6, 4, k);
    check("exempt chan runs", 32'(k > 0), 32'h1);
    syncIn <= 1'b0;
    $display("sync and holdover test done");
    complete_run();
  end
endmodule // test_dual_loop_clock_routing
